// file: lmd_dot_pwm.sv
// dot duty, mode selection and short flag registers with row scan output
`timescale 1ns/10ps
`include "lmd_defs.svh"
module lmd_dot_pwm import lmd_pkg::*; #(
  parameter int STEP_CYC = `LMD_STEP_CYC,
  parameter int GAP_CYC = `LMD_GAP_CYC
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [1:0] i_page,
  input wire logic [7:0] i_addr,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  input wire logic [7:0] i_breathing_profile_one,
  input wire logic [7:0] i_breathing_profile_two,
  input wire logic [7:0] i_breathing_profile_three,
  input wire logic [11:0] i_short_sense,
  output logic [11:0] o_row_scan_switch,
  output logic [11:0] o_column_current_source
);

  // ---------------------------------------------------------------
  // address decoding
  // ---------------------------------------------------------------
  function automatic logic dot_valid(input logic [7:0] a);
    dot_valid = (a[7:4] < 4'(`LMD_ROWS)) && (a[2:0] < 3'(`LMD_BYTE_FLAGS));
  endfunction : dot_valid

  function automatic logic [7:0] dot_index(input logic [7:0] a);
    dot_index = 8'(a[7:4] * 8'd12) + (a[3] ? 8'd6 : 8'd0) + 8'(a[2:0]);
  endfunction : dot_index

  // first dot of a six-flag byte in a two-bytes-per-row block
  function automatic logic [7:0] byte_base(input logic [7:0] off);
    byte_base = 8'(off[7:1] * 8'd12) + (off[0] ? 8'd6 : 8'd0);
  endfunction : byte_base

  logic [7:0] duty [`LMD_DOTS];
  logic [1:0] breath_profile_selector [`LMD_DOTS];
  logic [`LMD_DOTS-1:0] dot_on;
  logic [`LMD_DOTS-1:0] dot_short_flag;
  logic [`LMD_DOTS-1:0] shadow;
  logic breath_en;
  logic fault_detect_trigger;
  logic trig_prev;
  lmd_det_state_t det_state;
  lmd_det_state_t next_det_state;

  wire [7:0] short_off = i_addr - `LMD_SHORT_FIRST;
  wire wr_duty = i_wr && (i_page == `LMD_PAGE_DUTY) && dot_valid(i_addr);
  wire wr_mode = i_wr && (i_page == `LMD_PAGE_MODE) && dot_valid(i_addr);
  wire wr_onoff = i_wr && (i_page == `LMD_PAGE_CTRL) && (i_addr <= `LMD_ONOFF_LAST);
  wire wr_cfg = i_wr && (i_page == `LMD_PAGE_FUNC) && (i_addr == `LMD_CFG_ADDR);
  wire rd_short = (i_page == `LMD_PAGE_CTRL) && (i_addr >= `LMD_SHORT_FIRST) &&
    (i_addr <= `LMD_SHORT_LAST);
  wire [7:0] wr_dot = dot_index(i_addr);
  wire [7:0] onoff_base = byte_base(i_addr);
  wire [7:0] short_base = byte_base(short_off);
  wire [7:0] next_rdata = (i_rd && rd_short) ? {2'b00, dot_short_flag[short_base +: 6]} : 8'h00;

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      for (int i = 0; i < `LMD_DOTS; i++) begin
        duty[i] <= `LMD_DUTY_RESET;
        breath_profile_selector[i] <= `LMD_MODE_RESET;
      end
      dot_on <= '0;
      breath_en <= 1'b0;
      fault_detect_trigger <= 1'b0;
    end else begin
      if (wr_duty) begin
        duty[wr_dot] <= i_wdata;
      end
      if (wr_mode) begin
        breath_profile_selector[wr_dot] <= i_wdata[1:0];
      end
      if (wr_onoff) begin
        dot_on[onoff_base +: 6] <= i_wdata[5:0];
      end
      if (wr_cfg) begin
        breath_en <= i_wdata[`LMD_CFG_BEN_BIT];
        fault_detect_trigger <= i_wdata[`LMD_CFG_TRIG_BIT];
      end
    end
  end

  // ---------------------------------------------------------------
  // reads, free of side effects
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_rdata <= 8'h00;
      o_rvalid <= 1'b0;
    end else begin
      o_rdata <= next_rdata;
      o_rvalid <= i_rd;
    end
  end

  // ---------------------------------------------------------------
  // row scan and duty step
  // ---------------------------------------------------------------
  logic [3:0] row;
  logic [7:0] step;
  logic active;
  logic row_end;

  lmd_scan_timer #(
    .STEP_CYC(STEP_CYC),
    .GAP_CYC(GAP_CYC)
  ) u_timer (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .o_row(row),
    .o_step(step),
    .o_active(active),
    .o_row_end(row_end)
  );

  wire [7:0] row_base = 8'(row * 8'd12);
  wire [11:0] next_row_switch = active ? 12'(12'h001 << row) : 12'h000;
  logic [7:0] col_level [`LMD_COLS];
  logic [11:0] next_col;

  for (genvar c = 0; c < `LMD_COLS; c++) begin : g_col
    wire [7:0] dot = row_base + 8'(c);
    wire [1:0] sel = breath_profile_selector[dot];
    wire [7:0] prof_level = (sel == LMD_MODE_PROF_ONE) ? i_breathing_profile_one :
      (sel == LMD_MODE_PROF_TWO) ? i_breathing_profile_two : i_breathing_profile_three;
    assign col_level[c] = (breath_en && (sel != LMD_MODE_DUTY)) ? prof_level : duty[dot];
    assign next_col[c] = active && dot_on[dot] && (step < col_level[c]);
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_row_scan_switch <= 12'h000;
      o_column_current_source <= 12'h000;
    end else begin
      o_row_scan_switch <= next_row_switch;
      o_column_current_source <= next_col;
    end
  end

  // ---------------------------------------------------------------
  // short detection pass
  // ---------------------------------------------------------------
  wire det_start = fault_detect_trigger && !trig_prev;
  wire last_row = (row == 4'(`LMD_ROWS - 1));
  wire det_commit = (det_state == LMD_DET_RUN) && row_end && last_row;

  always_comb begin
    next_det_state = det_state;
    unique case (det_state)
      LMD_DET_IDLE: begin
        if (det_start) begin
          next_det_state = LMD_DET_WAIT;
        end
      end
      LMD_DET_WAIT: begin
        if (row_end && last_row) begin
          next_det_state = LMD_DET_RUN;
        end
      end
      LMD_DET_RUN: begin
        if (det_commit) begin
          next_det_state = LMD_DET_IDLE;
        end
      end
      default: begin
        next_det_state = LMD_DET_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      det_state <= LMD_DET_IDLE;
      trig_prev <= 1'b0;
      shadow <= '0;
      dot_short_flag <= '0;
    end else begin
      det_state <= next_det_state;
      trig_prev <= fault_detect_trigger;
      if ((det_state == LMD_DET_RUN) && row_end) begin
        shadow[row_base +: 12] <= i_short_sense;
      end
      if (det_commit) begin
        dot_short_flag <= {i_short_sense, shadow[131:0]};
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);

  a_short_pad_zero: assert property (o_rvalid |-> (o_rdata[7:6] == 2'b00))
    else $error("unused short bits not zero");
  a_short_first_map: assert property (i_rd && (i_page == 2'h0) && (i_addr == 8'h31) |=>
    (o_rdata == {2'b00, $past(dot_short_flag[11:6])}))
    else $error("second short byte of first row misread");
  a_duty_last_dot: assert property (i_wr && (i_page == 2'h1) && (i_addr == 8'hbd) |=>
    (duty[143] == $past(i_wdata)))
    else $error("last duty byte not stored");
  a_mode_map: assert property (i_wr && (i_page == 2'h2) && (i_addr == 8'h18) |=>
    (breath_profile_selector[18] == $past(i_wdata[1:0])))
    else $error("mode byte stored at wrong dot");
  a_col_on_time: assert property (o_column_current_source[0] |->
    ($past(step) < $past(col_level[0])) && $past(active))
    else $error("column driven beyond its duty");
  a_breath_off_duty: assert property (!breath_en |-> (col_level[5] == duty[row_base + 8'd5]))
    else $error("profile used while breathing disabled");
  a_dot_dark: assert property (!dot_on[row_base] |=> !o_column_current_source[0])
    else $error("disabled dot was driven");
  a_flags_hold: assert property (!det_commit |=> $stable(dot_short_flag))
    else $error("short flags changed outside a pass end");
  a_trig_once: assert property ((det_state == LMD_DET_IDLE) && fault_detect_trigger && trig_prev |=>
    (det_state == LMD_DET_IDLE))
    else $error("detection restarted without a fresh edge");
  a_row_onehot: assert property ((o_row_scan_switch != 12'h000) |-> $onehot(o_row_scan_switch))
    else $error("more than one row switch on");

endmodule : lmd_dot_pwm

// file: lmd_defs.svh
// constants of the dot matrix duty and mode block
`ifndef LMD_DEFS_SVH
`define LMD_DEFS_SVH

// ---------------------------------------------------------------
// register pages and offsets
// ---------------------------------------------------------------
`define LMD_PAGE_CTRL 2'h0
`define LMD_PAGE_DUTY 2'h1
`define LMD_PAGE_MODE 2'h2
`define LMD_PAGE_FUNC 2'h3
`define LMD_ONOFF_LAST 8'h17
`define LMD_SHORT_FIRST 8'h30
`define LMD_SHORT_LAST 8'h47
`define LMD_DOT_LAST 8'hbd
`define LMD_CFG_ADDR 8'h00

// ---------------------------------------------------------------
// fields and reset values
// ---------------------------------------------------------------
`define LMD_CFG_TRIG_BIT 2
`define LMD_CFG_BEN_BIT 1
`define LMD_BYTE_FLAGS 6
`define LMD_ROWS 12
`define LMD_COLS 12
`define LMD_DOTS 144
`define LMD_DUTY_RESET 8'h00
`define LMD_MODE_RESET 2'h0
`define LMD_STEPS 256

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define LMD_CLK_PERIOD_PS 5000
`define LMD_SLOT_PS 128000000
`define LMD_GAP_PS 8000000
`define LMD_SLOT_CYC (`LMD_SLOT_PS / `LMD_CLK_PERIOD_PS)
`define LMD_STEP_CYC (`LMD_SLOT_CYC / `LMD_STEPS)
`define LMD_GAP_CYC (`LMD_GAP_PS / `LMD_CLK_PERIOD_PS)

`endif

// file: lmd_pkg.sv
// types of the dot matrix duty and mode block
package lmd_pkg;

  typedef enum logic [1:0] {
    LMD_MODE_DUTY = 2'h0,
    LMD_MODE_PROF_ONE = 2'h1,
    LMD_MODE_PROF_TWO = 2'h2,
    LMD_MODE_PROF_THREE = 2'h3
  } lmd_mode_t;

  typedef enum logic [1:0] {
    LMD_DET_IDLE = 2'h0,
    LMD_DET_WAIT = 2'h1,
    LMD_DET_RUN = 2'h3
  } lmd_det_state_t;

endpackage : lmd_pkg

// file: lmd_scan_timer.sv
// row scan and duty step timer
`timescale 1ns/10ps
`include "lmd_defs.svh"
module lmd_scan_timer #(
  parameter int STEP_CYC = `LMD_STEP_CYC,
  parameter int GAP_CYC = `LMD_GAP_CYC
) (
  input wire logic i_clk,
  input wire logic i_reset,
  output logic [3:0] o_row,
  output logic [7:0] o_step,
  output logic o_active,
  output logic o_row_end
);

  logic [15:0] div;
  logic [15:0] gap;
  logic in_gap;
  logic [4:0] gap_run;

  wire div_last = (div == 16'(STEP_CYC - 1));
  wire gap_last = (gap == 16'(GAP_CYC - 1));
  wire row_last = (o_row == 4'(`LMD_ROWS - 1));

  assign o_active = !in_gap;
  assign o_row_end = !in_gap && div_last && (o_step == 8'hff);

  // ---------------------------------------------------------------
  // active slot of 256 steps, then blanking gap
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      div <= 16'h0000;
      gap <= 16'h0000;
      in_gap <= 1'b0;
      o_step <= 8'h00;
      o_row <= 4'h0;
    end else if (!in_gap) begin
      div <= div_last ? 16'h0000 : div + 16'h0001;
      if (div_last) begin
        o_step <= o_step + 8'h01;
      end
      if (o_row_end) begin
        in_gap <= 1'b1;
      end
    end else begin
      gap <= gap_last ? 16'h0000 : gap + 16'h0001;
      if (gap_last) begin
        in_gap <= 1'b0;
        o_row <= row_last ? 4'h0 : o_row + 4'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);

  always_ff @(posedge i_clk) begin
    if (i_reset || !in_gap) begin
      gap_run <= 5'h00;
    end else if (gap_run != 5'h1f) begin
      gap_run <= gap_run + 5'h01;
    end
  end

  a_gap_length: assert property (in_gap && !$past(in_gap) |-> in_gap [*3] ##0 1)
    else $error("blanking gap ended early");
  a_row_wrap: assert property (in_gap && gap_last && row_last |=> (o_row == 4'h0))
    else $error("row scan did not wrap to the first row");
  a_gap_count: assert property (in_gap && gap_last |->
    ((GAP_CYC >= 32) ? (gap_run == 5'h1f) : (gap_run == 5'(GAP_CYC - 1))))
    else $error("blanking gap length differs from its count");

endmodule : lmd_scan_timer

// file: lmd_matrix_model.sv
// dot matrix model: shorted dots drive sense, on-time counters
`timescale 1ns/10ps
module lmd_matrix_model (
  input wire logic i_clk,
  input wire logic i_clear,
  input wire logic [143:0] i_shorted,
  input wire logic [11:0] i_row,
  input wire logic [11:0] i_col,
  output logic [11:0] o_sense
);
  int on_cnt [12][12];
  int row_cnt [12];
  int gap_cnt;
  logic [11:0] last = 12'h000;
  // no row selected: sense toggles every cycle
  always_comb begin
    o_sense = ~last;
    for (int r = 0; r < 12; r++)
      if (i_row[r]) o_sense = i_shorted[r*12 +: 12];
  end
  always @(posedge i_clk) begin
    last <= o_sense;
    gap_cnt <= i_clear ? 0 : gap_cnt + int'(i_row == 12'h000);
    for (int r = 0; r < 12; r++) begin
      row_cnt[r] <= i_clear ? 0 : row_cnt[r] + int'(i_row[r]);
      for (int c = 0; c < 12; c++)
        on_cnt[r][c] <= i_clear ? 0 : on_cnt[r][c] + int'(i_row[r] && i_col[c]);
    end
  end
endmodule : lmd_matrix_model

// file: led_matrix_dot_pwm_and_mode_select_bench.sv
// self-checking bench of the dot duty and mode block
`timescale 1ns/10ps
module led_matrix_dot_pwm_and_mode_select_bench;
  localparam int STEP = 2;
  localparam int FRAME = 12 * (256 * STEP + 4);
  logic clk = 0, rst = 1, wr = 0, rd = 0, clear = 0, ben = 0, rvalid;
  logic [1:0] page = 0;
  logic [7:0] addr = 0, wdata = 0, rdata, p1 = 0, p2 = 0, p3 = 0, lfsr = 8'h05;
  logic [11:0] sense, rows, cols;
  logic [143:0] shorted = 0, flags = 0, on_bits = 0;
  logic [7:0] duty [144] = '{default: 8'h00};
  logic [1:0] mode [144] = '{default: 2'h0};
  logic [7:0] exp_q [$];
  int miscompares = 0, check_count = 0;

  lmd_dot_pwm #(.STEP_CYC(STEP), .GAP_CYC(4)) lmd_dot_pwm_i (.i_clk(clk), .i_reset(rst), .i_page(page),
    .i_addr(addr), .i_wr(wr), .i_wdata(wdata), .i_rd(rd), .o_rdata(rdata), .o_rvalid(rvalid),
    .i_breathing_profile_one(p1), .i_breathing_profile_two(p2), .i_breathing_profile_three(p3),
    .i_short_sense(sense), .o_row_scan_switch(rows), .o_column_current_source(cols));
  lmd_matrix_model lmd_matrix_model_i (.i_clk(clk), .i_clear(clear), .i_shorted(shorted), .i_row(rows),
    .i_col(cols), .o_sense(sense));

  initial begin
    forever #2.5 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
    check_count++;
    if (seen !== want) begin
      miscompares++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, want, seen);
    end
  endtask : check

  task automatic report_and_stop();
    if (miscompares == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  function automatic logic [7:0] rnd();
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    return lfsr;
  endfunction : rnd

  // one access per cycle; reads queue the expected byte
  task automatic acc(input logic w, input logic [1:0] pg, input logic [7:0] a, input logic [7:0] d);
    wr = w;
    rd = !w;
    page = pg;
    addr = a;
    wdata = d;
    if (!w) exp_q.push_back(d);
    @(negedge clk);
  endtask : acc

  task automatic idle();
    wr = 0;
    rd = 0;
    @(negedge clk);
  endtask : idle

  task automatic wr_dot(input int pg, input int n, input logic [7:0] d);
    if (pg == 1) duty[n] = d;
    else mode[n] = d[1:0];
    acc(1, 2'(pg), {4'(n / 12), 4'(n % 12 < 6 ? n % 12 : n % 12 + 2)}, d);
  endtask : wr_dot

  task automatic wr_on(input int k, input logic [7:0] d);
    on_bits[k*6 +: 6] = d[5:0];
    acc(1, 2'h0, 8'(k), d);
  endtask : wr_on

  task automatic read_shorts();
    for (int k = 0; k < 24; k++) acc(0, 2'h0, 8'(8'h30 + k), {2'b00, flags[k*6 +: 6]});
    idle();
  endtask : read_shorts

  function automatic logic [7:0] lvl(input int n);
    if (!on_bits[n]) return 8'h00;
    if (!ben || mode[n] == 2'h0) return duty[n];
    return mode[n] == 2'h1 ? p1 : mode[n] == 2'h2 ? p2 : p3;
  endfunction : lvl

  task automatic check_scan();
    repeat (4) @(negedge clk);
    clear = 1;
    @(negedge clk);
    clear = 0;
    repeat (FRAME) @(negedge clk);
    check(lmd_matrix_model_i.gap_cnt, 12 * 4, "gap cycles");
    for (int n = 0; n < 144; n++) begin
      if (n < 12) check(lmd_matrix_model_i.row_cnt[n], 256 * STEP, "row slot");
      check(lmd_matrix_model_i.on_cnt[n / 12][n % 12], lvl(n) * STEP, "dot on time");
    end
  endtask : check_scan

  always @(negedge clk) begin
    if (rvalid === 1'b1) begin
      if (exp_q.size() == 0) check(1, 0, "unexpected read");
      else check(rdata, exp_q.pop_front(), "read data");
    end
  end

  initial begin
    repeat (20) @(negedge clk);
    rst = 0;
    p1 = rnd();
    p2 = rnd();
    p3 = rnd();
    for (int i = 0; i < 18; i++) shorted[i*8 +: 8] = rnd();
    read_shorts();
    acc(0, 2'h1, 8'h00, 8'h00);
    acc(0, 2'h0, 8'h48, 8'h00);
    wr_on(0, 8'hff);
    wr_on(1, 8'h3f);
    wr_on(2, 8'h0f);
    wr_on(23, 8'h3f);
    wr_dot(1, 1, 8'h01);
    wr_dot(1, 2, 8'hff);
    wr_dot(1, 3, 8'h80);
    wr_dot(1, 6, rnd());
    wr_dot(1, 16, 8'hff);
    wr_dot(1, 143, rnd());
    wr_dot(2, 18, rnd());
    for (int n = 12; n < 16; n++) begin
      wr_dot(1, n, rnd());
      wr_dot(2, n, 8'hfc | 8'(n - 12));
    end
    // unused duty locations must not alias any dot
    acc(1, 2'h1, 8'h06, 8'hff);
    acc(1, 2'h1, 8'hc0, 8'hff);
    idle();
    check_scan();
    ben = 1;
    acc(1, 2'h3, 8'h00, 8'h02);
    idle();
    check_scan();
    acc(1, 2'h3, 8'h00, 8'h06);
    idle();
    repeat (3 * FRAME) @(negedge clk);
    flags = shorted;
    read_shorts();
    read_shorts();
    for (int i = 0; i < 18; i++) shorted[i*8 +: 8] = rnd();
    acc(1, 2'h3, 8'h00, 8'h06);
    idle();
    repeat (3 * FRAME) @(negedge clk);
    read_shorts();
    acc(1, 2'h3, 8'h00, 8'h02);
    acc(1, 2'h3, 8'h00, 8'h06);
    idle();
    repeat (3 * FRAME) @(negedge clk);
    flags = shorted;
    read_shorts();
    rst = 1;
    repeat (2) @(negedge clk);
    rst = 0;
    flags = 0;
    read_shorts();
    for (int i = 0; i < 8 && exp_q.size() != 0; i++) @(negedge clk);
    check(exp_q.size(), 0, "pending reads");
    report_and_stop();
  end
endmodule : led_matrix_dot_pwm_and_mode_select_bench
